// File: design/mrrs_pkg.sv
/*
 * Constants for the round robin multiplexer sequencer: register offsets,
 * reset values, field positions, frame codes and enumerations.
 * Assumes 16-bit serial frames: read flag, 7-bit address, 8-bit data.
 */
package mrrs_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_SWITCH_SELECT_AND_OUTPUTS = 7'h01;
   localparam logic [6:0] ADDR_ERROR_CHECK_ENABLES = 7'h02;
   localparam logic [6:0] ADDR_ERROR_INDICATORS = 7'h03;
   localparam logic [6:0] ADDR_CONSECUTIVE_FRAME_ENABLE = 7'h05;
   localparam logic [6:0] ADDR_SEQUENCING_ENABLE = 7'h06;
   localparam logic [6:0] ADDR_SEQUENCE_CHANNEL_MASK = 7'h07;
   localparam logic [6:0] ADDR_STROBE_EDGE_CHOICE = 7'h09;
   localparam logic [6:0] ADDR_SOFTWARE_RESET_KEY = 7'h0B;

   // ----------------------------------------------------------------
   // Reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_ERROR_CHECK_ENABLES = 8'h06;
   localparam logic [7:0] RST_SEQUENCE_CHANNEL_MASK = 8'hFF;
   localparam logic [7:0] MASK_ERROR_CHECK_ENABLES = 8'h07;
   localparam logic [7:0] MASK_SINGLE_BIT = 8'h01;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SW_EN_BIT = 0;
   localparam int SW_SEL_LSB = 1;
   localparam int SW_AUX_LSB = 4;
   localparam int RR_EN_BIT = 0;
   localparam int EDGE_SEL_BIT = 0;
   localparam int ERR_RW_BIT = 2;
   localparam int FRAME_READ_BIT = 15;
   localparam int FRAME_ADDR_LSB = 8;

   // ----------------------------------------------------------------
   // Frame codes and link timing
   // ----------------------------------------------------------------
   localparam logic [7:0] ALIGN_BYTE = 8'h25;
   localparam logic [15:0] EXIT_FIRST_FRAME = 16'hA318;
   localparam logic [15:0] EXIT_SECOND_FRAME = 16'hE3B4;
   localparam logic [15:0] ERROR_CLEAR_FRAME = 16'h6CA9;
   localparam logic [7:0] SOFT_KEY_FIRST = 8'hA3;
   localparam logic [7:0] SOFT_KEY_SECOND = 8'h05;
   localparam logic [4:0] FRAME_LAST_EDGE = 5'h0F;
   localparam logic [4:0] ADDR_LAST_EDGE = 5'h07;
   localparam logic [4:0] ALIGN_LEN = 5'h08;
   localparam logic [4:0] FRAME_LEN = 5'h10;
   localparam logic [4:0] BIT_CNT_MAX = 5'h1F;
   localparam logic [2:0] CH_TOP = 3'h7;
   localparam int NUM_CH = 8;

   // ----------------------------------------------------------------
   // Modes
   // ----------------------------------------------------------------
   typedef enum logic {MRRS_ADDRESSED, MRRS_ROUND_ROBIN} mrrs_mode_t;

endpackage

// File: design/mrrs_sequencer.sv
/*
 * Round robin multiplexer sequencer: serial register access, switch
 * decode, auxiliary outputs and strobe-driven channel stepping.
 * Assumes a mode 0 serial host on link_sclk/cs_n/sdi/sdo and a converter
 * strobe on conversion_strobe; both are asynchronous to core_clk.
 */
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Sequence includes only channels enabled in mask
// - Advance on strobe edge picked by edge register
// - After last channel, resync pulse in the same cycle as the wrap
// - Setting sequencing enable enters round robin mode
// - Channels step on strobe while select low
// - Leave mode on reset or two exit frames
// - Round robin ignores all frames but exit
// - Stepping needs no serial clock activity
// - Auxiliary outputs follow switch register bits
// - Auxiliary outputs low during round robin mode
// - Enable clear means none; else one channel
// - Two key writes restore register defaults
module mrrs_sequencer (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial link
   input wire logic link_sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   // Converter strobe
   input wire logic conversion_strobe,
   // Multiplexer control
   output logic mux_enable,
   output logic channel_sel_bit0,
   output logic channel_sel_bit1,
   output logic channel_sel_bit2,
   output logic [mrrs_pkg::NUM_CH-1:0] switch_on,
   // Auxiliary outputs
   output logic aux_output_1,
   output logic aux_output_2,
   output logic aux_output_3,
   output logic aux_output_4,
   // Status
   output logic rr_active
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Next enabled channel above cur, else lowest; MSB flags a wrap
   function automatic logic [3:0] find_next(input logic [7:0] mask, input logic [2:0] cur);
      logic [3:0] res;
      res = {1'b0, cur};
      for (int i = mrrs_pkg::NUM_CH - 1; i >= 0; i--) begin
         if (mask[i]) begin
            res = {1'b1, 3'(i)};
         end
      end
      for (int i = mrrs_pkg::NUM_CH - 1; i >= 0; i--) begin
         if (mask[i] && (3'(i) > cur)) begin
            res = {1'b0, 3'(i)};
         end
      end
      return res;
   endfunction

   function automatic logic addr_known(input logic [6:0] a);
      return (a == mrrs_pkg::ADDR_SWITCH_SELECT_AND_OUTPUTS)
         || (a == mrrs_pkg::ADDR_ERROR_CHECK_ENABLES)
         || (a == mrrs_pkg::ADDR_ERROR_INDICATORS)
         || (a == mrrs_pkg::ADDR_CONSECUTIVE_FRAME_ENABLE)
         || (a == mrrs_pkg::ADDR_SEQUENCING_ENABLE)
         || (a == mrrs_pkg::ADDR_SEQUENCE_CHANNEL_MASK)
         || (a == mrrs_pkg::ADDR_STROBE_EDGE_CHOICE)
         || (a == mrrs_pkg::ADDR_SOFTWARE_RESET_KEY);
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic rst_meta, rst_sync_n, tog_s1, tog_s2, tog_s3, cs_s1, cs_s2, cnv_s1, cnv_s2, cnv_s3;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [15:0] shift_in, next_shift_in, word_hold, next_word_hold;
   logic [6:0] rd_addr, next_rd_addr, f_addr;
   logic rd_req, next_rd_req, frame_tog, next_frame_tog, sdo_link, next_sdo_link;
   logic [7:0] rd_data, f_data;
   mrrs_pkg::mrrs_mode_t mode, next_mode;
   logic [7:0] switch_select_and_outputs, next_switch_select_and_outputs, err_cfg, next_err_cfg, err_flags, next_err_flags;
   logic [7:0] burst_en, next_burst_en, rr_en, next_rr_en, rr_mask, next_rr_mask;
   logic [7:0] edge_sel, next_edge_sel, soft_key, next_soft_key, next_switch_on;
   logic soft_armed, next_soft_armed, exit_armed, next_exit_armed, resync, next_resync;
   logic frame_evt, strobe_evt, f_read, next_mux_enable;
   logic [2:0] rr_chan, next_rr_chan, next_sel;
   logic [3:0] step, first_step, next_aux;

   // ----------------------------------------------------------------
   // Reset release and synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         {tog_s1, tog_s2, tog_s3, cnv_s1, cnv_s2, cnv_s3} <= 6'h00;
         {cs_s1, cs_s2} <= 2'h3;
      end else begin
         tog_s1 <= frame_tog;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
         cs_s1 <= cs_n;
         cs_s2 <= cs_s1;
         cnv_s1 <= conversion_strobe;
         cnv_s2 <= cnv_s1;
         cnv_s3 <= cnv_s2;
      end
   end

   // ----------------------------------------------------------------
   // Link side: frame receive on rising serial clock
   // ----------------------------------------------------------------
   always_comb begin
      next_bit_cnt = bit_cnt;
      if (bit_cnt != mrrs_pkg::BIT_CNT_MAX) begin
         next_bit_cnt = 5'(bit_cnt + 5'h01);
      end
      next_shift_in = {shift_in[14:0], sdi};
      next_rd_addr = rd_addr;
      next_rd_req = rd_req;
      if (bit_cnt == mrrs_pkg::ADDR_LAST_EDGE) begin
         next_rd_addr = {shift_in[5:0], sdi};
         next_rd_req = shift_in[6];
      end
      next_word_hold = word_hold;
      next_frame_tog = frame_tog;
      if (bit_cnt == mrrs_pkg::FRAME_LAST_EDGE) begin
         next_word_hold = {shift_in[14:0], sdi};
         next_frame_tog = ~frame_tog;
      end
   end

   always_ff @(posedge link_sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt <= 5'h00;
         shift_in <= 16'h0000;
         rd_addr <= 7'h00;
         rd_req <= 1'b0;
      end else begin
         bit_cnt <= next_bit_cnt;
         shift_in <= next_shift_in;
         rd_addr <= next_rd_addr;
         rd_req <= next_rd_req;
      end
   end

   // Held word stays stable until the next frame's last edge
   always_ff @(posedge link_sclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         word_hold <= 16'h0000;
         frame_tog <= 1'b0;
      end else begin
         word_hold <= next_word_hold;
         frame_tog <= next_frame_tog;
      end
   end

   // ----------------------------------------------------------------
   // Link side: reply on falling serial clock
   // ----------------------------------------------------------------
   always_comb begin
      rd_data = mrrs_pkg::RST_ZERO;
      if (rd_addr == mrrs_pkg::ADDR_SWITCH_SELECT_AND_OUTPUTS) begin
         rd_data = switch_select_and_outputs;
      end else if (rd_addr == mrrs_pkg::ADDR_ERROR_CHECK_ENABLES) begin
         rd_data = err_cfg;
      end else if (rd_addr == mrrs_pkg::ADDR_ERROR_INDICATORS) begin
         rd_data = err_flags;
      end else if (rd_addr == mrrs_pkg::ADDR_CONSECUTIVE_FRAME_ENABLE) begin
         rd_data = burst_en;
      end else if (rd_addr == mrrs_pkg::ADDR_SEQUENCING_ENABLE) begin
         rd_data = rr_en;
      end else if (rd_addr == mrrs_pkg::ADDR_SEQUENCE_CHANNEL_MASK) begin
         rd_data = rr_mask;
      end else if (rd_addr == mrrs_pkg::ADDR_STROBE_EDGE_CHOICE) begin
         rd_data = edge_sel;
      end else if (rd_addr == mrrs_pkg::ADDR_SOFTWARE_RESET_KEY) begin
         rd_data = soft_key;
      end
      next_sdo_link = 1'b0;
      if ((bit_cnt != 5'h00) && (bit_cnt <= mrrs_pkg::ALIGN_LEN)) begin
         next_sdo_link = mrrs_pkg::ALIGN_BYTE[3'(mrrs_pkg::ALIGN_LEN - bit_cnt)];
      end else if ((bit_cnt > mrrs_pkg::ALIGN_LEN) && (bit_cnt <= mrrs_pkg::FRAME_LEN)) begin
         next_sdo_link = rd_req && (mode == mrrs_pkg::MRRS_ADDRESSED)
            && rd_data[3'(mrrs_pkg::ALIGN_LEN - bit_cnt)];
      end
   end

   always_ff @(negedge link_sclk or posedge cs_n) begin
      if (cs_n) begin
         sdo_link <= 1'b0;
      end else begin
         sdo_link <= next_sdo_link;
      end
   end

   // ----------------------------------------------------------------
   // Core side: registers and sequencer
   // ----------------------------------------------------------------
   assign frame_evt = tog_s2 ^ tog_s3;
   assign f_read = word_hold[mrrs_pkg::FRAME_READ_BIT];
   assign f_addr = word_hold[14:mrrs_pkg::FRAME_ADDR_LSB];
   assign f_data = word_hold[7:0];
   assign strobe_evt = ~cs_s2
      && (edge_sel[mrrs_pkg::EDGE_SEL_BIT] ? (cnv_s3 && !cnv_s2)
                                           : (cnv_s2 && !cnv_s3));
   assign step = find_next(rr_mask, rr_chan);
   assign first_step = find_next(rr_mask, mrrs_pkg::CH_TOP);

   always_comb begin
      next_mode = mode;
      next_switch_select_and_outputs = switch_select_and_outputs;
      next_err_cfg = err_cfg;
      next_err_flags = err_flags;
      next_burst_en = burst_en;
      next_rr_en = rr_en;
      next_rr_mask = rr_mask;
      next_edge_sel = edge_sel;
      next_soft_key = soft_key;
      next_soft_armed = soft_armed;
      next_exit_armed = exit_armed;
      next_rr_chan = rr_chan;
      next_resync = 1'b0;
      case (mode)
         mrrs_pkg::MRRS_ADDRESSED: begin
            if (frame_evt) begin
               next_soft_armed = 1'b0;
               if (word_hold == mrrs_pkg::ERROR_CLEAR_FRAME) begin
                  next_err_flags = mrrs_pkg::RST_ZERO;
               end else if (!addr_known(f_addr)
                  || (!f_read && (f_addr == mrrs_pkg::ADDR_ERROR_INDICATORS))) begin
                  if (err_cfg[mrrs_pkg::ERR_RW_BIT]) begin
                     next_err_flags[mrrs_pkg::ERR_RW_BIT] = 1'b1;
                  end
               end else if (!f_read) begin
                  if (f_addr == mrrs_pkg::ADDR_SWITCH_SELECT_AND_OUTPUTS) begin
                     next_switch_select_and_outputs = f_data;
                  end else if (f_addr == mrrs_pkg::ADDR_ERROR_CHECK_ENABLES) begin
                     next_err_cfg = f_data & mrrs_pkg::MASK_ERROR_CHECK_ENABLES;
                  end else if (f_addr == mrrs_pkg::ADDR_CONSECUTIVE_FRAME_ENABLE) begin
                     next_burst_en = f_data & mrrs_pkg::MASK_SINGLE_BIT;
                  end else if (f_addr == mrrs_pkg::ADDR_SEQUENCING_ENABLE) begin
                     next_rr_en = f_data & mrrs_pkg::MASK_SINGLE_BIT;
                     if (f_data[mrrs_pkg::RR_EN_BIT]) begin
                        next_mode = mrrs_pkg::MRRS_ROUND_ROBIN;
                        next_rr_chan = first_step[2:0];
                        next_exit_armed = 1'b0;
                     end
                  end else if (f_addr == mrrs_pkg::ADDR_SEQUENCE_CHANNEL_MASK) begin
                     next_rr_mask = f_data;
                  end else if (f_addr == mrrs_pkg::ADDR_STROBE_EDGE_CHOICE) begin
                     next_edge_sel = f_data & mrrs_pkg::MASK_SINGLE_BIT;
                  end else if (f_addr == mrrs_pkg::ADDR_SOFTWARE_RESET_KEY) begin
                     next_soft_key = f_data;
                     next_soft_armed = (f_data == mrrs_pkg::SOFT_KEY_FIRST);
                     if (soft_armed && (f_data == mrrs_pkg::SOFT_KEY_SECOND)) begin
                        next_switch_select_and_outputs = mrrs_pkg::RST_ZERO;
                        next_err_cfg = mrrs_pkg::RST_ERROR_CHECK_ENABLES;
                        next_err_flags = mrrs_pkg::RST_ZERO;
                        next_burst_en = mrrs_pkg::RST_ZERO;
                        next_rr_en = mrrs_pkg::RST_ZERO;
                        next_rr_mask = mrrs_pkg::RST_SEQUENCE_CHANNEL_MASK;
                        next_edge_sel = mrrs_pkg::RST_ZERO;
                        next_soft_key = mrrs_pkg::RST_ZERO;
                        next_soft_armed = 1'b0;
                     end
                  end
               end
            end
         end
         mrrs_pkg::MRRS_ROUND_ROBIN: begin
            if (frame_evt) begin
               next_exit_armed = (word_hold == mrrs_pkg::EXIT_FIRST_FRAME);
               if (exit_armed && (word_hold == mrrs_pkg::EXIT_SECOND_FRAME)) begin
                  next_mode = mrrs_pkg::MRRS_ADDRESSED;
                  next_rr_en = mrrs_pkg::RST_ZERO;
                  next_exit_armed = 1'b0;
               end
            end
            if (strobe_evt && (rr_mask != mrrs_pkg::RST_ZERO)) begin
               next_rr_chan = step[2:0];
               next_resync = step[3];
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mode <= mrrs_pkg::MRRS_ADDRESSED;
         err_cfg <= mrrs_pkg::RST_ERROR_CHECK_ENABLES;
         rr_mask <= mrrs_pkg::RST_SEQUENCE_CHANNEL_MASK;
         {switch_select_and_outputs, err_flags, burst_en, rr_en, edge_sel, soft_key} <= {6{mrrs_pkg::RST_ZERO}};
         {rr_chan, soft_armed, exit_armed, resync} <= 6'h00;
      end else begin
         mode <= next_mode;
         switch_select_and_outputs <= next_switch_select_and_outputs;
         err_cfg <= next_err_cfg;
         err_flags <= next_err_flags;
         burst_en <= next_burst_en;
         rr_en <= next_rr_en;
         rr_mask <= next_rr_mask;
         edge_sel <= next_edge_sel;
         soft_key <= next_soft_key;
         soft_armed <= next_soft_armed;
         exit_armed <= next_exit_armed;
         rr_chan <= next_rr_chan;
         resync <= next_resync;
      end
   end

   // ----------------------------------------------------------------
   // Output decode and registers
   // ----------------------------------------------------------------
   always_comb begin
      if (next_mode == mrrs_pkg::MRRS_ROUND_ROBIN) begin
         next_mux_enable = (next_rr_mask != mrrs_pkg::RST_ZERO);
         next_sel = next_rr_chan;
         next_aux = 4'h0;
      end else begin
         next_mux_enable = next_switch_select_and_outputs[mrrs_pkg::SW_EN_BIT];
         next_sel = next_switch_select_and_outputs[mrrs_pkg::SW_SEL_LSB +: 3];
         next_aux = next_switch_select_and_outputs[mrrs_pkg::SW_AUX_LSB +: 4];
      end
      next_switch_on = 8'h00;
      if (next_mux_enable) begin
         next_switch_on[next_sel] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         {mux_enable, channel_sel_bit2, channel_sel_bit1, channel_sel_bit0} <= 4'h0;
         {aux_output_4, aux_output_3, aux_output_2, aux_output_1, rr_active} <= 5'h00;
         switch_on <= 8'h00;
      end else begin
         mux_enable <= next_mux_enable;
         {channel_sel_bit2, channel_sel_bit1, channel_sel_bit0} <= next_sel;
         switch_on <= next_switch_on;
         {aux_output_4, aux_output_3, aux_output_2, aux_output_1} <= next_aux;
         rr_active <= (next_mode == mrrs_pkg::MRRS_ROUND_ROBIN);
      end
   end

   // Resync pulse shares the serial output line
   assign sdo = sdo_link | resync;

endmodule

`default_nettype wire

// File: dv/mrrs_host_model.sv
/* Serial host and converter strobe model.
   Assumes mode 0 framing; the serial clock stands low outside frames. */
`timescale 1ns/100ps
`default_nettype none
module mrrs_host_model (
   // Core clock for strobe timing
   input wire logic core_clk,
   // Serial link
   output logic link_sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo,
   // Converter strobe
   output logic conversion_strobe
);
   // ----------------------------------------
   // Frame and strobe tasks
   // ----------------------------------------
   logic framing;
   initial begin
      link_sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      conversion_strobe = 1'b0;
      framing = 1'b0;
   end
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      #2.3;
      framing = 1'b1;
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = w[i];
         #14;
         link_sclk = 1'b1;
         #15;
         link_sclk = 1'b0;
         #1;
         r[i] = sdo;
      end
      #15;
      cs_n = 1'b1;
      sdi = ~sdi;
      #60;
      framing = 1'b0;
   endtask
   task automatic strobe_to(input logic lvl, input logic sel);
      @(posedge core_clk);
      cs_n <= ~sel;
      repeat (4) @(posedge core_clk);
      conversion_strobe <= lvl;
      repeat (8) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// File: dv/mrrs_sequencer_asserts.sv
/* Port checker for the round robin multiplexer sequencer.
   Assumes a bind onto mrrs_sequencer; watches the core_clk domain only. */
`timescale 1ns/100ps
`default_nettype none
module mrrs_sequencer_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial link and strobe
   input wire logic link_sclk,
   input wire logic cs_n,
   input wire logic sdo,
   input wire logic conversion_strobe,
   // Multiplexer and status
   input wire logic mux_enable,
   input wire logic channel_sel_bit0,
   input wire logic channel_sel_bit1,
   input wire logic channel_sel_bit2,
   input wire logic [mrrs_pkg::NUM_CH-1:0] switch_on,
   input wire logic aux_output_1,
   input wire logic aux_output_2,
   input wire logic aux_output_3,
   input wire logic aux_output_4,
   input wire logic rr_active
);
   // ----------------------------------------
   // Activity age counters
   // ----------------------------------------
   logic [3:0] sclk_age;
   logic [3:0] next_sclk_age;
   logic [3:0] stb_age;
   logic [3:0] next_stb_age;
   logic stb_q;
   logic [2:0] chan;
   assign chan = {channel_sel_bit2, channel_sel_bit1, channel_sel_bit0};
   always_comb begin
      next_sclk_age = (sclk_age == 4'hF) ? 4'hF : sclk_age + 4'h1;
      next_stb_age = (stb_age == 4'hF) ? 4'hF : stb_age + 4'h1;
      if (link_sclk) begin
         next_sclk_age = 4'h0;
      end
      if (conversion_strobe != stb_q) begin
         next_stb_age = 4'h0;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_age <= 4'hF;
         stb_age <= 4'hF;
         stb_q <= 1'b0;
      end else begin
         sclk_age <= next_sclk_age;
         stb_age <= next_stb_age;
         stb_q <= conversion_strobe;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   aux_low_rr_a: assert property (rr_active && $past(rr_active) |->
      {aux_output_4, aux_output_3, aux_output_2, aux_output_1} == 4'h0)
      else $error("aux output high in round robin");
   switch_decode_a: assert property (mux_enable |-> switch_on == (8'h01 << chan))
      else $error("switch_on not one-hot of channel");
   switch_off_a: assert property (!mux_enable |-> switch_on == 8'h00)
      else $error("switch closed while disabled");
   step_on_strobe_a: assert property (rr_active && $past(rr_active) && $changed(chan)
      |-> stb_age inside {[4'h1:4'h5]}) else $error("channel moved without strobe edge");
   resync_width_a: assert property (rr_active && sclk_age > 4'h8 && $rose(sdo)
      |-> chan <= $past(chan) ##1 !sdo) else $error("bad resync pulse");
   mode_change_a: assert property ($changed(rr_active) |-> sclk_age <= 4'h8)
      else $error("mode changed without a frame");
   addr_sel_frame_a: assert property (!rr_active && $changed(chan) |-> sclk_age <= 4'h8)
      else $error("addressed channel moved without a frame");
   sdo_idle_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> !sdo)
      else $error("sdo high while deselected");
   cover property ($rose(rr_active));
   cover property (rr_active && sclk_age > 4'h8 && $rose(sdo));
   cover property ($fell(rr_active));
endmodule
bind mrrs_sequencer mrrs_sequencer_asserts u_asserts (.core_clk(core_clk), .rst_n(rst_n),
   .link_sclk(link_sclk), .cs_n(cs_n), .sdo(sdo), .conversion_strobe(conversion_strobe),
   .mux_enable(mux_enable), .channel_sel_bit0(channel_sel_bit0),
   .channel_sel_bit1(channel_sel_bit1), .channel_sel_bit2(channel_sel_bit2),
   .switch_on(switch_on), .aux_output_1(aux_output_1), .aux_output_2(aux_output_2),
   .aux_output_3(aux_output_3), .aux_output_4(aux_output_4), .rr_active(rr_active));
`default_nettype wire

// File: dv/tb_top.sv
/* Self-checking bench for mrrs_sequencer.
   Assumes mrrs_host_model drives the link and the strobe. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic core_clk, rst_n, link_sclk, cs_n, sdi, sdo, conversion_strobe, mux_enable;
   logic channel_sel_bit0, channel_sel_bit1, channel_sel_bit2, rr_active;
   logic aux_output_1, aux_output_2, aux_output_3, aux_output_4;
   logic [7:0] switch_on;
   logic [15:0] rd;
   int fail_count = 0;
   int check_count = 0;
   int pulses = 0;
   mrrs_sequencer u_dut (.core_clk(core_clk), .rst_n(rst_n), .link_sclk(link_sclk),
      .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .conversion_strobe(conversion_strobe),
      .mux_enable(mux_enable), .channel_sel_bit0(channel_sel_bit0),
      .channel_sel_bit1(channel_sel_bit1), .channel_sel_bit2(channel_sel_bit2),
      .switch_on(switch_on), .aux_output_1(aux_output_1), .aux_output_2(aux_output_2),
      .aux_output_3(aux_output_3), .aux_output_4(aux_output_4), .rr_active(rr_active));
   mrrs_host_model u_host (.core_clk(core_clk), .link_sclk(link_sclk), .cs_n(cs_n),
      .sdi(sdi), .sdo(sdo), .conversion_strobe(conversion_strobe));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (!u_host.framing && sdo === 1'b1) begin
         pulses <= pulses + 1;
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_host.xfer({1'b0, a, d}, rd);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      u_host.xfer({1'b1, a, 8'h00}, rd);
      check("read", rd, {mrrs_pkg::ALIGN_BYTE, exp});
   endtask
   task automatic pins(input logic rr, input logic [3:0] aux, input logic en,
                       input logic [2:0] ch);
      check("pins", {rr_active, aux_output_4, aux_output_3, aux_output_2, aux_output_1,
         mux_enable, channel_sel_bit2, channel_sel_bit1, channel_sel_bit0, switch_on},
         {rr, aux, en, ch, en ? 8'h01 << ch : 8'h00});
   endtask
   task automatic defaults();
      logic [6:0] a [8] = '{7'h01, 7'h02, 7'h03, 7'h05, 7'h06, 7'h07, 7'h09, 7'h0B};
      logic [7:0] v [8] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rd_chk(a[i], v[i]);
      end
   endtask
   // ----------------------------------------
   // Sequence and watchdog
   // ----------------------------------------
   initial begin
      logic [2:0] walk [4];
      walk = '{3'h3, 3'h5, 3'h0, 3'h3};
      rst_n = 1'b0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      defaults();
      for (int ch = 0; ch < 8; ch++) begin
         wr(7'h01, {4'(15 - ch), 3'(ch), 1'b1});
         pins(1'b0, 4'(15 - ch), 1'b1, 3'(ch));
      end
      wr(7'h01, 8'hA0);
      pins(1'b0, 4'hA, 1'b0, 3'h0);
      wr(7'h04, 8'h55);
      rd_chk(7'h03, 8'h04);
      wr(7'h07, 8'h12);
      wr(7'h0B, 8'hA3);
      wr(7'h0B, 8'h05);
      defaults();
      wr(7'h01, 8'hF1);
      wr(7'h07, 8'h29);
      wr(7'h06, 8'h01);
      pins(1'b1, 4'h0, 1'b1, 3'h0);
      wr(7'h01, 8'h03);
      pins(1'b1, 4'h0, 1'b1, 3'h0);
      u_host.strobe_to(1'b1, 1'b0);
      u_host.strobe_to(1'b0, 1'b0);
      pins(1'b1, 4'h0, 1'b1, 3'h0);
      for (int k = 0; k < 4; k++) begin
         u_host.strobe_to(1'b1, 1'b1);
         pins(1'b1, 4'h0, 1'b1, walk[k]);
         u_host.strobe_to(1'b0, 1'b1);
         pins(1'b1, 4'h0, 1'b1, walk[k]);
      end
      check("resync", 24'(pulses), 24'h1);
      u_host.xfer(mrrs_pkg::EXIT_FIRST_FRAME, rd);
      wr(7'h01, 8'h01);
      u_host.xfer(mrrs_pkg::EXIT_SECOND_FRAME, rd);
      pins(1'b1, 4'h0, 1'b1, 3'h3);
      u_host.xfer(mrrs_pkg::EXIT_FIRST_FRAME, rd);
      u_host.xfer(mrrs_pkg::EXIT_SECOND_FRAME, rd);
      pins(1'b0, 4'hF, 1'b1, 3'h0);
      rd_chk(7'h06, 8'h00);
      wr(7'h09, 8'h01);
      wr(7'h07, 8'h06);
      wr(7'h06, 8'h01);
      pins(1'b1, 4'h0, 1'b1, 3'h1);
      u_host.strobe_to(1'b1, 1'b1);
      pins(1'b1, 4'h0, 1'b1, 3'h1);
      u_host.strobe_to(1'b0, 1'b1);
      pins(1'b1, 4'h0, 1'b1, 3'h2);
      u_host.strobe_to(1'b1, 1'b1);
      u_host.strobe_to(1'b0, 1'b1);
      pins(1'b1, 4'h0, 1'b1, 3'h1);
      check("resync", 24'(pulses), 24'h2);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      pins(1'b0, 4'h0, 1'b0, 3'h0);
      end_of_test();
   end
   initial begin
      #300000;
      fail_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
